// ---- nfc_pkg.sv ----
/*
 * nfc_pkg: constants for the host-side parallel NOR flash controller.
 * Assumes a 2M x 16 flash with a one- and two-cycle command set.
 */
package nfc_pkg;
	// command bytes, low data byte only
	localparam logic [7:0] CMD_READ_ARRAY = 8'h_FF;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h_20;
	localparam logic [7:0] CMD_CONFIRM = 8'h_D0;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h_40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h_10;
	localparam logic [7:0] CMD_SUSPEND = 8'h_B0;
	localparam logic [7:0] CMD_PRODUCT_ID = 8'h_90;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h_60;
	localparam logic [7:0] CMD_SOFTLOCK = 8'h_01;
	localparam logic [7:0] CMD_HARDLOCK = 8'h_2F;
	localparam logic [7:0] CMD_READ_STATUS = 8'h_70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h_50;
	localparam logic [7:0] CMD_PROT_SETUP = 8'h_C0;
	localparam logic [7:0] CMD_CFI_QUERY = 8'h_98;
	localparam logic [15:0] PROT_LOCK_DATA = 16'h_FFFD;
	localparam logic [20:0] PROT_LOCK_ADDR = 21'h_00_0080;
	localparam logic [20:0] PROT_BASE_ADDR = 21'h_00_0081;
	localparam int PROT_WORDS = 8;
	// status bits
	localparam int SR_READY_BIT = 7;
	localparam int SR_FAIL_BIT = 4;
	localparam int SR_VPP_BIT = 3;
	localparam int SR_LOCKED_BIT = 1;
	localparam int OTP_LOCK_BIT = 1;
	// sector map, bottom boot
	localparam int SMALL_SECTORS = 8;
	localparam int SMALL_SHIFT = 12;
	localparam int LARGE_SHIFT = 15;
	localparam logic [20:0] LARGE_BASE = 21'h_00_8000;
	// controller registers
	localparam logic [3:0] REG_CTRL = 4'h_0;
	localparam logic [3:0] REG_ADDR = 4'h_1;
	localparam logic [3:0] REG_WDATA = 4'h_2;
	localparam logic [3:0] REG_STAT = 4'h_3;
	localparam logic [3:0] REG_RDATA = 4'h_4;
	localparam logic [3:0] REG_SECTOR = 4'h_5;
	// operation codes written to REG_CTRL[3:0]
	localparam logic [3:0] OP_READ = 4'h_0;
	localparam logic [3:0] OP_ERASE = 4'h_1;
	localparam logic [3:0] OP_PROGRAM = 4'h_2;
	localparam logic [3:0] OP_SUSPEND = 4'h_3;
	localparam logic [3:0] OP_RESUME = 4'h_4;
	localparam logic [3:0] OP_PRODUCT_ID = 4'h_5;
	localparam logic [3:0] OP_SOFTLOCK = 4'h_6;
	localparam logic [3:0] OP_HARDLOCK = 4'h_7;
	localparam logic [3:0] OP_UNLOCK = 4'h_8;
	localparam logic [3:0] OP_READ_STATUS = 4'h_9;
	localparam logic [3:0] OP_CLEAR_STATUS = 4'h_A;
	localparam logic [3:0] OP_PROT_PROGRAM = 4'h_B;
	localparam logic [3:0] OP_PROT_LOCK = 4'h_C;
	localparam logic [3:0] OP_PROT_STATUS = 4'h_D;
	localparam logic [3:0] OP_CFI = 4'h_E;
	localparam logic [3:0] OP_RAW_READ = 4'h_F;
	// bus timing, 20 MHz clock
	localparam int CLK_PERIOD_NS = 50;
	localparam int ACCESS_NS = 70;
	localparam int WE_PULSE_NS = 50;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// edges from pin to the third stage of the data synchroniser; the agreed word needs one edge more
	localparam int SYNC_CYC = 3;
	localparam logic [3:0] RESET_CTRL = 4'h_0;
	localparam logic [15:0] RESET_DATA = 16'h_0000;
endpackage

// ---- nfc_bus_cycle.sv ----
/*
 * nfc_bus_cycle: runs one asynchronous write or read cycle on the flash pins.
 * Assumes the flash needs no clock and that ce/oe/we are active low.
 */
`timescale 1ns/1ps
module nfc_bus_cycle #(
	parameter int HOLD_CYC = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [20:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] dq_sync_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] rdata_o,
	output logic [20:0] fl_addr_o,
	output logic fl_ce_n_o,
	output logic fl_oe_n_o,
	output logic fl_we_n_o,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe_o
);
	typedef enum logic [1:0] {
		NFC_BC_IDLE = 2'b00,
		NFC_BC_STROBE = 2'b01,
		NFC_BC_RECOVER = 2'b10
	} nfc_bc_e;

	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC > 255 - nfc_pkg::SYNC_CYC) begin
			$error("nfc_bus_cycle: HOLD_CYC out of range");
		end
	end

	nfc_bc_e state_ff;
	logic [7:0] cnt_ff;
	logic wr_ff;

	assign busy_o = (state_ff != NFC_BC_IDLE);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= NFC_BC_IDLE;
			cnt_ff <= 8'h_00;
			wr_ff <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h_0000;
			fl_addr_o <= 21'h_00_0000;
			fl_ce_n_o <= 1'b1;
			fl_oe_n_o <= 1'b1;
			fl_we_n_o <= 1'b1;
			fl_dq_o <= 16'h_0000;
			fl_dq_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			done_o <= 1'b0;
			case (state_ff)
				NFC_BC_IDLE: begin
					if (start_i) begin
						wr_ff <= write_i;
						fl_addr_o <= addr_i;
						fl_dq_o <= wdata_i;
						fl_dq_oe_o <= write_i;
						fl_ce_n_o <= 1'b0;
						fl_we_n_o <= !write_i;
						fl_oe_n_o <= write_i;
						// reads stay strobed until pin data has crossed the synchroniser
						cnt_ff <= write_i ? 8'(HOLD_CYC) : 8'(HOLD_CYC + nfc_pkg::SYNC_CYC);
						state_ff <= NFC_BC_STROBE;
					end
				end
				NFC_BC_STROBE: begin
					if (cnt_ff > 8'h_01) begin
						cnt_ff <= cnt_ff - 8'h_01;
					end else begin
						// we rises first; data held one more cycle for hold time
						fl_we_n_o <= 1'b1;
						fl_oe_n_o <= 1'b1;
						if (!wr_ff) begin
							rdata_o <= dq_sync_i;
						end
						state_ff <= NFC_BC_RECOVER;
					end
				end
				NFC_BC_RECOVER: begin
					fl_ce_n_o <= 1'b1;
					fl_dq_oe_o <= 1'b0;
					done_o <= 1'b1;
					state_ff <= NFC_BC_IDLE;
				end
				default: begin
					state_ff <= NFC_BC_IDLE;
				end
			endcase
		end
	end
endmodule

// ---- nfc_ctrl.sv ----
/*
 * nfc_ctrl: host controller that turns register orders into flash command
 * sequences and reports results. Assumes a plain register port and a flash
 * that decodes the command set below; data pins pass a three-stage sync.
 */
// Added by the designer: the strobed register port and the placing of the registers.
// What this block does
// - erase: 20 then D0 at sector address
// - program: 40, then address and word
// - B0 suspends, D0 resumes operation
// - 90 enters product identification mode
// - 50 clears status error bits
// - protection program: C0, then address and word
// - lock user half: C0 then FFFD at 80
// - 98 enters CFI query mode
// - protection words at 81..88, upper address zero
`timescale 1ns/1ps
module nfc_ctrl #(
	parameter int HOLD_CYC = nfc_pkg::WE_CYC + nfc_pkg::ACCESS_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic [20:0] fl_addr_o,
	output logic fl_ce_n_o,
	output logic fl_oe_n_o,
	output logic fl_we_n_o,
	input wire logic [15:0] fl_dq_i,
	output logic [15:0] fl_dq_o,
	output logic fl_dq_oe_o
);
	typedef enum logic [1:0] {
		NFC_IDLE = 2'b00,
		NFC_CYC1 = 2'b01,
		NFC_CYC2 = 2'b10,
		NFC_WAIT = 2'b11
	} nfc_state_e;

	initial begin
		if (HOLD_CYC < 1) $error("nfc_ctrl: HOLD_CYC must be at least one");
	end

	// sector index of a word address; any word in the sector maps the same
	function automatic logic [6:0] sector_of(input logic [20:0] a);
		if (a < nfc_pkg::LARGE_BASE) begin
			sector_of = 7'(a >> nfc_pkg::SMALL_SHIFT);
		end else begin
			sector_of = 7'((a >> nfc_pkg::LARGE_SHIFT) + nfc_pkg::SMALL_SECTORS - 1);
		end
	endfunction

	// three-stage sync on data pins; only stages two and three are read
	logic [15:0] dq_s1_ff, dq_s2_ff, dq_s3_ff, dq_stable_ff;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dq_s1_ff <= 16'h_0000;
			dq_s2_ff <= 16'h_0000;
			dq_s3_ff <= 16'h_0000;
			dq_stable_ff <= 16'h_0000;
		end else if (clk_en_i) begin
			dq_s1_ff <= fl_dq_i;
			dq_s2_ff <= dq_s1_ff;
			dq_s3_ff <= dq_s2_ff;
			if (dq_s2_ff == dq_s3_ff) begin
				dq_stable_ff <= dq_s3_ff;
			end
		end
	end

	logic [3:0] op_ff;
	logic [20:0] addr_ff;
	logic [15:0] wdata_ff, rdata_ff;
	logic [6:0] sector_ff;
	logic bad_addr_ff, otp_locked_ff;
	nfc_state_e state_ff;
	logic bc_start, bc_write, bc_busy, bc_done;
	logic [20:0] bc_addr;
	logic [15:0] bc_wdata, bc_rdata;
	logic [7:0] first_cmd, second_cmd;
	logic two_cycle, second_is_read;

	// command bytes per operation; high data byte sent as zero
	always_comb begin
		first_cmd = nfc_pkg::CMD_READ_ARRAY;
		second_cmd = nfc_pkg::CMD_READ_ARRAY;
		two_cycle = 1'b0;
		second_is_read = 1'b0;
		case (op_ff)
			nfc_pkg::OP_READ: first_cmd = nfc_pkg::CMD_READ_ARRAY;
			nfc_pkg::OP_ERASE: begin
				first_cmd = nfc_pkg::CMD_ERASE_SETUP;
				second_cmd = nfc_pkg::CMD_CONFIRM;
				two_cycle = 1'b1;
			end
			nfc_pkg::OP_PROGRAM: begin
				first_cmd = nfc_pkg::CMD_PROG_SETUP;
				two_cycle = 1'b1;
			end
			nfc_pkg::OP_SUSPEND: first_cmd = nfc_pkg::CMD_SUSPEND;
			nfc_pkg::OP_RESUME: first_cmd = nfc_pkg::CMD_CONFIRM;
			nfc_pkg::OP_PRODUCT_ID: first_cmd = nfc_pkg::CMD_PRODUCT_ID;
			nfc_pkg::OP_SOFTLOCK, nfc_pkg::OP_HARDLOCK, nfc_pkg::OP_UNLOCK: begin
				first_cmd = nfc_pkg::CMD_LOCK_SETUP;
				second_cmd = (op_ff == nfc_pkg::OP_SOFTLOCK) ? nfc_pkg::CMD_SOFTLOCK :
					(op_ff == nfc_pkg::OP_HARDLOCK) ? nfc_pkg::CMD_HARDLOCK : nfc_pkg::CMD_CONFIRM;
				two_cycle = 1'b1;
			end
			nfc_pkg::OP_READ_STATUS: begin
				first_cmd = nfc_pkg::CMD_READ_STATUS;
				two_cycle = 1'b1;
				second_is_read = 1'b1;
			end
			nfc_pkg::OP_CLEAR_STATUS: first_cmd = nfc_pkg::CMD_CLEAR_STATUS;
			nfc_pkg::OP_PROT_PROGRAM, nfc_pkg::OP_PROT_LOCK: begin
				first_cmd = nfc_pkg::CMD_PROT_SETUP;
				two_cycle = 1'b1;
			end
			nfc_pkg::OP_PROT_STATUS: begin
				first_cmd = nfc_pkg::CMD_PRODUCT_ID;
				two_cycle = 1'b1;
				second_is_read = 1'b1;
			end
			nfc_pkg::OP_CFI: first_cmd = nfc_pkg::CMD_CFI_QUERY;
			nfc_pkg::OP_RAW_READ: second_is_read = 1'b1;
			default: first_cmd = nfc_pkg::CMD_READ_ARRAY;
		endcase
	end

	// address and data of the cycle now due
	always_comb begin
		bc_start = 1'b0;
		bc_write = 1'b1;
		bc_addr = addr_ff;
		bc_wdata = {8'h_00, first_cmd};
		if (state_ff == NFC_CYC1 && !bc_busy) begin
			bc_start = 1'b1;
			if (op_ff == nfc_pkg::OP_RAW_READ) begin
				bc_write = 1'b0;
			end
		end else if (state_ff == NFC_CYC2 && !bc_busy) begin
			bc_start = 1'b1;
			bc_write = !second_is_read;
			case (op_ff)
				nfc_pkg::OP_PROGRAM, nfc_pkg::OP_PROT_PROGRAM: bc_wdata = wdata_ff;
				nfc_pkg::OP_PROT_LOCK: begin
					bc_addr = nfc_pkg::PROT_LOCK_ADDR;
					bc_wdata = nfc_pkg::PROT_LOCK_DATA;
				end
				nfc_pkg::OP_PROT_STATUS: bc_addr = nfc_pkg::PROT_LOCK_ADDR;
				default: bc_wdata = {8'h_00, second_cmd};
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= NFC_IDLE;
			op_ff <= nfc_pkg::RESET_CTRL;
			addr_ff <= 21'h_00_0000;
			wdata_ff <= nfc_pkg::RESET_DATA;
			sector_ff <= 7'h_00;
			bad_addr_ff <= 1'b0;
		end else if (clk_en_i) begin
			if (reg_wr_i && reg_addr_i == nfc_pkg::REG_ADDR && state_ff == NFC_IDLE) begin
				addr_ff <= reg_wdata_i[20:0];
				sector_ff <= sector_of(reg_wdata_i[20:0]);
			end
			if (reg_wr_i && reg_addr_i == nfc_pkg::REG_WDATA && state_ff == NFC_IDLE) begin
				wdata_ff <= reg_wdata_i[15:0];
			end
			case (state_ff)
				NFC_IDLE: begin
					// orders while busy are ignored; software polls the busy bit
					if (reg_wr_i && reg_addr_i == nfc_pkg::REG_CTRL) begin
						op_ff <= reg_wdata_i[3:0];
						state_ff <= NFC_CYC1;
						bad_addr_ff <= 1'b0;
						if (reg_wdata_i[3:0] == nfc_pkg::OP_PROT_PROGRAM &&
							(addr_ff < nfc_pkg::PROT_BASE_ADDR ||
							addr_ff >= nfc_pkg::PROT_BASE_ADDR + 21'(nfc_pkg::PROT_WORDS))) begin
							bad_addr_ff <= 1'b1;
							state_ff <= NFC_IDLE;
						end
					end
				end
				NFC_CYC1: begin
					if (bc_start) begin
						state_ff <= two_cycle ? NFC_CYC2 : NFC_WAIT;
					end
				end
				NFC_CYC2: begin
					if (bc_done) begin
						state_ff <= NFC_WAIT;
					end
				end
				NFC_WAIT: begin
					// second cycle only issued once the first has fully ended
					if (bc_done) begin
						state_ff <= NFC_IDLE;
					end
				end
				default: state_ff <= NFC_IDLE;
			endcase
		end
	end

	// read results: status byte, lock flag
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 16'h_0000;
			otp_locked_ff <= 1'b0;
		end else if (clk_en_i && bc_done && state_ff == NFC_WAIT) begin
			if (op_ff == nfc_pkg::OP_READ_STATUS) begin
				rdata_ff <= {8'h_00, bc_rdata[7:0]};
			end else begin
				rdata_ff <= bc_rdata;
			end
			if (op_ff == nfc_pkg::OP_PROT_STATUS) begin
				otp_locked_ff <= !bc_rdata[nfc_pkg::OTP_LOCK_BIT];
			end
		end
	end

	// register reads, data one cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h_0000_0000;
		end else if (clk_en_i) begin
			reg_rdata_o <= 32'h_0000_0000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					nfc_pkg::REG_CTRL: reg_rdata_o <= {28'h_000_0000, op_ff};
					nfc_pkg::REG_ADDR: reg_rdata_o <= {11'h_000, addr_ff};
					nfc_pkg::REG_WDATA: reg_rdata_o <= {16'h_0000, wdata_ff};
					nfc_pkg::REG_STAT: reg_rdata_o <= {29'h_0000_0000, otp_locked_ff, bad_addr_ff,
						state_ff != NFC_IDLE};
					nfc_pkg::REG_RDATA: reg_rdata_o <= {16'h_0000, rdata_ff};
					nfc_pkg::REG_SECTOR: reg_rdata_o <= {25'h_000_0000, sector_ff};
					default: reg_rdata_o <= 32'h_0000_0000;
				endcase
			end
		end
	end

	nfc_bus_cycle #(
		.HOLD_CYC(HOLD_CYC)
	) u_cycle (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i),
		.start_i(bc_start),
		.write_i(bc_write),
		.addr_i(bc_addr),
		.wdata_i(bc_wdata),
		.dq_sync_i(dq_stable_ff),
		.busy_o(bc_busy),
		.done_o(bc_done),
		.rdata_o(bc_rdata),
		.fl_addr_o(fl_addr_o),
		.fl_ce_n_o(fl_ce_n_o),
		.fl_oe_n_o(fl_oe_n_o),
		.fl_we_n_o(fl_we_n_o),
		.fl_dq_o(fl_dq_o),
		.fl_dq_oe_o(fl_dq_oe_o)
	);
endmodule

// ---- nfc_ctrl_properties.sv ----
/*
 * nfc_ctrl_properties: pin-cycle checks on nfc_ctrl, watching its ports only.
 * Assumes clk_en_i stays high while a flash cycle is in flight.
 */
`timescale 1ns/1ps
module nfc_ctrl_properties #(
	parameter int HOLD_CYC = 3
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [20:0] fl_addr_o,
	input wire logic fl_ce_n_o,
	input wire logic fl_oe_n_o,
	input wire logic fl_we_n_o,
	input wire logic [15:0] fl_dq_i,
	input wire logic [15:0] fl_dq_o,
	input wire logic fl_dq_oe_o
);
	logic [7:0] low_cnt_ff;
	// counts strobe-low cycles so the width check needs no long repetition
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			low_cnt_ff <= 8'h_00;
		end else if (clk_en_i) begin
			low_cnt_ff <= (!fl_we_n_o || !fl_oe_n_o) ? low_cnt_ff + 8'h_01 : 8'h_00;
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_tail;
		fl_we_n_o && fl_oe_n_o && !fl_ce_n_o ##1 fl_ce_n_o && !fl_dq_oe_o;
	endsequence
	a_we_width: assert property ($rose(fl_we_n_o) |-> low_cnt_ff == 8'(HOLD_CYC))
		else $error("write strobe width wrong");
	a_oe_width: assert property ($rose(fl_oe_n_o) |-> low_cnt_ff == 8'(HOLD_CYC + nfc_pkg::SYNC_CYC))
		else $error("read strobe width wrong");
	a_write_tail: assert property ($rose(fl_we_n_o) |-> fl_dq_oe_o ##0 s_tail)
		else $error("write cycle end wrong");
	a_read_tail: assert property ($rose(fl_oe_n_o) |-> s_tail)
		else $error("read cycle end wrong");
	a_we_drives: assert property (!fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o && fl_oe_n_o)
		else $error("write strobe without drive");
	a_oe_no_drive: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o && fl_we_n_o)
		else $error("read strobe with drive");
	a_idle_quiet: assert property (fl_ce_n_o |-> fl_we_n_o && fl_oe_n_o && !fl_dq_oe_o)
		else $error("strobe while deselected");
	a_hold_stable: assert property (!fl_we_n_o && $past(!fl_we_n_o) |->
		$stable(fl_dq_o) && $stable(fl_addr_o))
		else $error("write data moved in strobe");
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h_0000_0000)
		else $error("read data outside slot");
endmodule
bind nfc_ctrl nfc_ctrl_properties #(.HOLD_CYC(HOLD_CYC)) u_nfc_ctrl_properties (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o),
	.fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
	.fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o));

// ---- nfc_flash_model.sv ----
/*
 * nfc_flash_model: behavioural bottom-boot NOR flash command decoder.
 * Assumes the bench resolves the shared data lines; always ready at once.
 */
`timescale 1ns/1ps
module nfc_flash_model (
	input wire logic [20:0] addr_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic drv_o
);
	logic [15:0] mem [int];
	logic [70:0] lock = '0;
	logic [7:0] pend = 8'h_00;
	logic [7:0] sr = 8'h_80;
	logic [7:0] c, np;
	logic [1:0] mode = 2'h_0;
	logic otp_lk = 1'b0;
	logic [20:0] l_addr = '0;
	logic [20:0] p_addr = '0;
	logic [15:0] l_data = '0;
	logic [15:0] p_data = '0;
	int n_wr = 0;
	function automatic int sec(input logic [20:0] a);
		return (a < 21'h_00_8000) ? int'(a >> 12) : 8 + int'((a - 21'h_00_8000) >> 15);
	endfunction
	assign #70 drv_o = !ce_n_i && !oe_n_i;
	always @(posedge we_n_i) begin
		if (!ce_n_i) begin
			p_addr = l_addr;
			p_data = l_data;
			l_addr = addr_i;
			l_data = dq_i;
			n_wr = n_wr + 1;
			c = dq_i[7:0];
			np = 8'h_00;
			if (pend == 8'h_40) begin
				if (lock[sec(addr_i)]) sr[1] = 1'b1;
				else mem[addr_i] = dq_i;
			end else if (pend == 8'h_60) begin
				if (c == 8'h_01 || c == 8'h_2F) lock[sec(addr_i)] = 1'b1;
				else if (c == 8'h_D0) lock[sec(addr_i)] = 1'b0;
			end else if (pend == 8'h_C0) begin
				if (addr_i[7:0] == 8'h_80 && dq_i == 16'h_FFFD) otp_lk = 1'b1;
				else if (addr_i >= 21'h_00_0081 && addr_i <= 21'h_00_0088) mem[addr_i] = dq_i;
			end else if (pend == 8'h_00) begin
				case (c)
					8'h_FF: mode = 2'h_0;
					8'h_70: mode = 2'h_1;
					8'h_90: mode = 2'h_2;
					8'h_98: mode = 2'h_3;
					8'h_50: sr = 8'h_80;
					8'h_20, 8'h_40, 8'h_60, 8'h_C0: np = c;
					8'h_10: np = 8'h_40;
					default: ;
				endcase
			end
			pend = np;
		end
	end
	// data settles after the address, never in the same step as oe
	always @(negedge oe_n_i) begin
		#10;
		if (mode == 2'h_1) dq_o = {8'h_00, sr};
		else if (mode == 2'h_2) dq_o = {14'h_0000, !otp_lk, 1'b0};
		else if (mem.exists(addr_i)) dq_o = mem[addr_i];
		else dq_o = addr_i[15:0] ^ 16'h_5A5A;
	end
endmodule

// ---- nfc_ctrl_tb.sv ----
/*
 * nfc_ctrl_tb: drives nfc_ctrl registers against the flash model.
 * Assumes the checker is bound to nfc_ctrl by its own file.
 */
`timescale 1ns/1ps
module nfc_ctrl_tb;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h_0;
	logic [31:0] reg_wdata_i = 32'h_0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic clk_en = 1'b1;
	logic [31:0] reg_rdata_o, s;
	logic [20:0] fl_addr_o;
	logic fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o, f_drv;
	logic [15:0] fl_dq_o, f_dq, dq_bus;
	logic [15:0] dq_last = 16'h_0000;
	int bad_count = 0;
	int total_checks = 0;
	int n;
	logic [19:0] two_tbl [5] = '{{nfc_pkg::OP_ERASE, 16'h_20D0},
		{nfc_pkg::OP_SOFTLOCK, 16'h_6001}, {nfc_pkg::OP_HARDLOCK, 16'h_602F},
		{nfc_pkg::OP_UNLOCK, 16'h_60D0}, {nfc_pkg::OP_PROGRAM, 16'h_405A}};
	logic [11:0] one_tbl [6] = '{{nfc_pkg::OP_READ, 8'h_FF}, {nfc_pkg::OP_SUSPEND, 8'h_B0},
		{nfc_pkg::OP_RESUME, 8'h_D0}, {nfc_pkg::OP_PRODUCT_ID, 8'h_90},
		{nfc_pkg::OP_CLEAR_STATUS, 8'h_50}, {nfc_pkg::OP_CFI, 8'h_98}};
	logic [27:0] sec_tbl [7] = '{{21'h_00_0FFF, 7'd0}, {21'h_00_1000, 7'd1},
		{21'h_00_7FFF, 7'd7}, {21'h_00_8000, 7'd8}, {21'h_00_FFFF, 7'd8},
		{21'h_01_0000, 7'd9}, {21'h_1F_FFFF, 7'd70}};
	// released lines show the inverse of the last driven value
	assign dq_bus = fl_dq_oe_o ? fl_dq_o : (f_drv ? f_dq : ~dq_last);
	always @(posedge sys_clk_i) if (fl_dq_oe_o || f_drv) dq_last <= dq_bus;
	initial forever #25 sys_clk_i = ~sys_clk_i;
	nfc_ctrl u_nfc_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_o(fl_addr_o),
		.fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
		.fl_dq_i(dq_bus), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o));
	nfc_flash_model u_nfc_flash_model (.addr_i(fl_addr_o), .ce_n_i(fl_ce_n_o),
		.oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .dq_i(dq_bus), .dq_o(f_dq), .drv_o(f_drv));
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task wait_idle();
		logic [31:0] st;
		for (int i = 0; i < 100; i++) begin
			rd(nfc_pkg::REG_STAT, st);
			if (st[0] === 1'b0) return;
		end
		bad_count++;
		$display("BAD busy exp 0 seen 1");
		give_verdict();
	endtask
	task op(input logic [20:0] a, input logic [15:0] w, input logic [3:0] c);
		wr(nfc_pkg::REG_ADDR, 32'(a));
		wr(nfc_pkg::REG_WDATA, 32'(w));
		wr(nfc_pkg::REG_CTRL, 32'(c));
		wait_idle();
	endtask
	task t_reset();
		wr(4'h_9, 32'h_FFFF_FFFF);
		for (int i = 0; i < 7; i++) begin
			rd((i == 6) ? 4'h_9 : 4'(i), s);
			chk("reset reg", s, 32'h_0000_0000);
		end
		$display("reset test done");
	endtask
	task t_single();
		for (int i = 0; i < 6; i++) begin
			n = u_nfc_flash_model.n_wr;
			op(21'h_1F_FF00, 16'h_0000, one_tbl[i][11:8]);
			chk("one cycle data", 32'(u_nfc_flash_model.l_data), 32'(one_tbl[i][7:0]));
			chk("one cycle count", 32'(u_nfc_flash_model.n_wr - n), 32'h_0000_0001);
		end
		$display("single command test done");
	endtask
	task t_two();
		logic [20:0] a;
		for (int i = 0; i < 5; i++) begin
			a = {i[4:0], 16'h_0123};
			op(a, 16'h_C35A, two_tbl[i][19:16]);
			chk("setup data", 32'(u_nfc_flash_model.p_data), 32'(two_tbl[i][15:8]));
			chk("second addr", 32'(u_nfc_flash_model.l_addr), 32'(a));
			chk("second data", 32'(u_nfc_flash_model.l_data),
				(i == 4) ? 32'h_0000_C35A : 32'(two_tbl[i][7:0]));
		end
		op(a, 16'h_0000, nfc_pkg::OP_RAW_READ);
		rd(nfc_pkg::REG_RDATA, s);
		chk("programmed word", s, 32'h_0000_C35A);
		$display("two cycle test done");
	endtask
	task t_sector();
		for (int i = 0; i < 7; i++) begin
			wr(nfc_pkg::REG_ADDR, 32'(sec_tbl[i][27:7]));
			rd(nfc_pkg::REG_SECTOR, s);
			chk("sector index", s, 32'(sec_tbl[i][6:0]));
		end
		$display("sector test done");
	endtask
	task t_status();
		op(21'h_00_4000, 16'h_0000, nfc_pkg::OP_SOFTLOCK);
		op(21'h_00_4FF5, 16'h_1111, nfc_pkg::OP_PROGRAM);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_READ);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_READ_STATUS);
		rd(nfc_pkg::REG_RDATA, s);
		chk("status error", s, 32'h_0000_0082);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_CLEAR_STATUS);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_READ_STATUS);
		rd(nfc_pkg::REG_RDATA, s);
		chk("status clear", s, 32'h_0000_0080);
		$display("status test done");
	endtask
	task t_prot();
		op(21'h_00_0081, 16'h_1234, nfc_pkg::OP_PROT_PROGRAM);
		chk("prot setup", 32'(u_nfc_flash_model.p_data), 32'h_0000_00C0);
		chk("prot addr", 32'(u_nfc_flash_model.l_addr), 32'h_0000_0081);
		chk("prot data", 32'(u_nfc_flash_model.l_data), 32'h_0000_1234);
		n = u_nfc_flash_model.n_wr;
		op(21'h_00_0089, 16'h_1234, nfc_pkg::OP_PROT_PROGRAM);
		rd(nfc_pkg::REG_STAT, s);
		chk("prot range", {s[1], 31'(u_nfc_flash_model.n_wr - n)}, 32'h_8000_0000);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_PROT_STATUS);
		rd(nfc_pkg::REG_STAT, s);
		chk("otp open", 32'(s[2]), 32'h_0000_0000);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_PROT_LOCK);
		chk("lock addr", 32'(u_nfc_flash_model.l_addr), 32'h_0000_0080);
		chk("lock data", 32'(u_nfc_flash_model.l_data), 32'h_0000_FFFD);
		op(21'h_00_0000, 16'h_0000, nfc_pkg::OP_PROT_STATUS);
		rd(nfc_pkg::REG_STAT, s);
		chk("otp locked", 32'(s[2]), 32'h_0000_0001);
		$display("protection test done");
	endtask
	task t_busy();
		wr(nfc_pkg::REG_ADDR, 32'h_0001_2345);
		wr(nfc_pkg::REG_CTRL, 32'(nfc_pkg::OP_PROGRAM));
		wr(nfc_pkg::REG_ADDR, 32'h_0000_0777);
		rd(nfc_pkg::REG_STAT, s);
		chk("busy flag", 32'(s[0]), 32'h_0000_0001);
		wait_idle();
		chk("busy addr", 32'(u_nfc_flash_model.l_addr), 32'h_0001_2345);
		rd(nfc_pkg::REG_ADDR, s);
		chk("addr kept", s, 32'h_0001_2345);
		$display("busy test done");
	endtask
	task t_freeze();
		wr(nfc_pkg::REG_ADDR, 32'h_0000_0111);
		clk_en <= 1'b0;
		wr(nfc_pkg::REG_ADDR, 32'h_0000_0222);
		wr(nfc_pkg::REG_CTRL, 32'(nfc_pkg::OP_READ));
		@(posedge sys_clk_i);
		chk("frozen pins", {fl_ce_n_o, fl_we_n_o, fl_dq_oe_o}, 32'h_0000_0006);
		clk_en <= 1'b1;
		rd(nfc_pkg::REG_STAT, s);
		chk("frozen busy", 32'(s[0]), 32'h_0000_0000);
		rd(nfc_pkg::REG_ADDR, s);
		chk("frozen addr", s, 32'h_0000_0111);
		$display("freeze test done");
	endtask
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_single();
		t_two();
		t_sector();
		t_status();
		t_prot();
		t_busy();
		t_freeze();
		give_verdict();
	end
endmodule
